// *** rtl/djk_defines.svh ***
/*
  Constants for the dual JK falling-edge flip-flop block.
  Assumes inclusion by bare name from design files.
*/
`ifndef DJK_DEFINES_SVH
`define DJK_DEFINES_SVH
// Variant codes
`define DJK_VAR_FULL 2'h0
`define DJK_VAR_SET_ONLY 2'h1
`define DJK_VAR_SHARED 2'h2
// Number of flip-flops
`define DJK_NUM_FF 2
// Reset value of stored state
`define DJK_RESET_STATE 1'h0
`endif

// *** rtl/djk_pkg.sv ***
/*
  Types for the dual JK flip-flop block.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package djk_pkg;
  // JK action selected at the edge
  typedef enum logic [3:0] {
    DJK_HOLD = 4'h1,
    DJK_CLR = 4'h2,
    DJK_SET = 4'h4,
    DJK_TGL = 4'h8
  } djk_act_t;
endpackage

// *** rtl/djk_sync.sv ***
/*
  Three-stage synchroniser for one pin; output changes once stages two
  and three agree. Assumes sys_clk_in is the only clock.
*/
`timescale 1ns/1ps
`default_nettype none
module djk_sync (
  input wire logic sys_clk_in, // System clock
  input wire logic rst_b_in, // Async reset, active low
  input wire logic pin_in, // Raw pin
  input wire logic init_in, // Reset level, constant; unused, all stages reset to 1
  output logic level_out // Filtered level
);
  logic s1_q;
  logic s2_q;
  logic s3_q;
  // Stage one is read only by stage two
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      s1_q <= 1'b1;
      s2_q <= 1'b1;
      s3_q <= 1'b1;
    end else begin
      s1_q <= pin_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end
  // Agreement filter hides single-cycle glitches
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      level_out <= 1'b1;
    end else if (s2_q == s3_q) begin
      level_out <= s3_q;
    end
  end
  logic unused_init;
  assign unused_init = init_in;
endmodule
`default_nettype wire

// *** rtl/djk_top.sv ***
/*
  Dual JK flip-flop, falling edge, with active-low direct set and clear,
  modelled on one system clock. Assumes all pins are asynchronous and
  change slower than the synchroniser latency.
*/
// How it works
// R1: Two flip-flops, each with its own inputs and outputs.
// R2: State updates only on clock falling edge while set and clear idle.
// R3: JK table: hold, clear, set, toggle.
// R4: J and K only matter at the falling edge.
// R5: Set forces true output high; clear forces complement high; clock blocked.
// R6: Set and clear act without any clock edge of the flip-flop clock.
// R7: Set and clear together drive both outputs high.
// R8: Set-only variant ignores clear; only asynchronous action is set.
// R9: Set-only variant takes inputs while clock high, moves on falling edge; here J/K are read only at the detected fall, as in all variants.
// R10: Shared variant uses one clock and one clear for both.
// R11: Complement is inverse of true output except set-and-clear case.
`timescale 1ns/1ps
`default_nettype none
`include "djk_defines.svh"
module djk_top #(
  parameter logic [1:0] VARIANT = `DJK_VAR_FULL // Variant select
) (
  input wire logic sys_clk_in, // System clock 100 MHz
  input wire logic rst_b_in, // Async reset, active low
  input wire logic [1:0] j_in, // J per flip-flop
  input wire logic [1:0] k_in, // K per flip-flop
  input wire logic [1:0] falling_edge_clock_in, // Per-ff clock pins
  input wire logic [1:0] set_b_in, // Direct set, active low
  input wire logic [1:0] clr_b_in, // Direct clear, active low
  output logic [1:0] q_out, // True outputs
  output logic [1:0] q_b_out // Complement outputs
);
  logic [1:0] clk_s;
  logic [1:0] clk_prev_q;
  logic [1:0] set_s;
  logic [1:0] clr_s;
  logic [1:0] clr_eff;
  logic [1:0] set_eff;
  logic [1:0] fall;
  logic [1:0] state_q;

  // JK decode, shared by both halves
  function automatic djk_pkg::djk_act_t jk_act(input logic j, input logic k);
    unique case ({j, k})
      2'b00: jk_act = djk_pkg::DJK_HOLD;
      2'b01: jk_act = djk_pkg::DJK_CLR;
      2'b10: jk_act = djk_pkg::DJK_SET;
      default: jk_act = djk_pkg::DJK_TGL;
    endcase
  endfunction

  function automatic logic jk_next(input djk_pkg::djk_act_t a, input logic s);
    unique case (a)
      djk_pkg::DJK_HOLD: jk_next = s;
      djk_pkg::DJK_CLR: jk_next = 1'b0;
      djk_pkg::DJK_SET: jk_next = 1'b1;
      default: jk_next = ~s;
    endcase
  endfunction

  // Pin synchronisers; shared variant uses pin 0 for clock and clear
  genvar gi;
  generate
    for (gi = 0; gi < `DJK_NUM_FF; gi++) begin : g_sync
      djk_sync u_clk (
        .sys_clk_in(sys_clk_in),
        .rst_b_in(rst_b_in),
        .pin_in((VARIANT == `DJK_VAR_SHARED) ? falling_edge_clock_in[0]
                : falling_edge_clock_in[gi]), // [R10]
        .init_in(1'b1),
        .level_out(clk_s[gi])
      );
      djk_sync u_set (
        .sys_clk_in(sys_clk_in),
        .rst_b_in(rst_b_in),
        .pin_in(set_b_in[gi]),
        .init_in(1'b1),
        .level_out(set_s[gi])
      );
      djk_sync u_clr (
        .sys_clk_in(sys_clk_in),
        .rst_b_in(rst_b_in),
        .pin_in((VARIANT == `DJK_VAR_SHARED) ? clr_b_in[0]
                : clr_b_in[gi]), // [R10]
        .init_in(1'b1),
        .level_out(clr_s[gi])
      );
    end
  endgenerate

  // Set-only variant has no clear at all
  assign clr_eff = (VARIANT == `DJK_VAR_SET_ONLY) ? 2'h0 : ~clr_s; // [R8]
  assign set_eff = ~set_s;
  // Falling edge seen on the synchronised clock
  assign fall = clk_prev_q & ~clk_s; // [R2] [R9]

  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      clk_prev_q <= 2'h3;
    end else begin
      clk_prev_q <= clk_s;
    end
  end

  // Stored state; direct inputs win and block the clock path.
  // Each half reads only its own J, K. J/K are sampled at the edge only,
  // so the caller must hold them steady across the sync latency.
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      state_q <= {2{`DJK_RESET_STATE}};
    end else begin
      for (int i = 0; i < `DJK_NUM_FF; i++) begin // [R1]
        if (set_eff[i]) begin
          state_q[i] <= 1'b1; // [R5] [R6]
        end else if (clr_eff[i]) begin
          state_q[i] <= 1'b0; // [R5] [R6]
        end else if (fall[i]) begin
          state_q[i] <= jk_next(jk_act(j_in[i], k_in[i]), state_q[i]); // [R3] [R4]
        end
      end
    end
  end

  // Outputs registered; both high when set and clear meet
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      q_out <= 2'h0;
      q_b_out <= 2'h3;
    end else begin
      for (int i = 0; i < `DJK_NUM_FF; i++) begin
        if (set_eff[i] && clr_eff[i]) begin
          q_out[i] <= 1'b1; // [R7]
          q_b_out[i] <= 1'b1; // [R7]
        end else if (set_eff[i]) begin
          q_out[i] <= 1'b1;
          q_b_out[i] <= 1'b0; // [R11]
        end else if (clr_eff[i]) begin
          q_out[i] <= 1'b0;
          q_b_out[i] <= 1'b1;
        end else if (fall[i]) begin
          q_out[i] <= jk_next(jk_act(j_in[i], k_in[i]), state_q[i]);
          q_b_out[i] <= ~jk_next(jk_act(j_in[i], k_in[i]), state_q[i]); // [R11]
        end else begin
          q_out[i] <= state_q[i];
          q_b_out[i] <= ~state_q[i];
        end
      end
    end
  end

  // Checks on direct inputs, both halves
  AST_BOTH_HIGH: assert property ( // [R7]
    @(posedge sys_clk_in) disable iff (!rst_b_in)
    (set_eff[0] && clr_eff[0]) |=> (q_out[0] && q_b_out[0]))
    else $error("set and clear together must drive both high");
  AST_BOTH_HIGH_B1: assert property ( // [R7]
    @(posedge sys_clk_in) disable iff (!rst_b_in)
    (set_eff[1] && clr_eff[1]) |=> (q_out[1] && q_b_out[1]))
    else $error("set and clear together must drive both high");
  AST_SET_WINS: assert property ( // [R5]
    @(posedge sys_clk_in) disable iff (!rst_b_in)
    (set_eff[1] && !clr_eff[1]) |=> (q_out[1] && !q_b_out[1]))
    else $error("set must force true output high");
  AST_SET_WINS_B0: assert property ( // [R5]
    @(posedge sys_clk_in) disable iff (!rst_b_in)
    (set_eff[0] && !clr_eff[0]) |=> (q_out[0] && !q_b_out[0]))
    else $error("set must force true output high");
  AST_CLR_WINS: assert property ( // [R5]
    @(posedge sys_clk_in) disable iff (!rst_b_in)
    (clr_eff[0] && !set_eff[0]) |=> (!q_out[0] && q_b_out[0]))
    else $error("clear must force complement high");
  AST_CLR_WINS_B1: assert property ( // [R5]
    @(posedge sys_clk_in) disable iff (!rst_b_in)
    (clr_eff[1] && !set_eff[1]) |=> (!q_out[1] && q_b_out[1]))
    else $error("clear must force complement high");
  // Clocked path: nothing moves without a detected fall
  AST_NO_EDGE_HOLD: assert property ( // [R2]
    @(posedge sys_clk_in) disable iff (!rst_b_in)
    (!fall[0] && !set_eff[0] && !clr_eff[0]) |=> $stable(state_q[0]))
    else $error("state changed without falling edge");
  AST_NO_EDGE_HOLD_B1: assert property ( // [R2]
    @(posedge sys_clk_in) disable iff (!rst_b_in)
    (!fall[1] && !set_eff[1] && !clr_eff[1]) |=> $stable(state_q[1]))
    else $error("state changed without falling edge");
  AST_TOGGLE: assert property ( // [R3]
    @(posedge sys_clk_in) disable iff (!rst_b_in)
    (fall[1] && !set_eff[1] && !clr_eff[1] && j_in[1] && k_in[1])
    |=> (state_q[1] != $past(state_q[1])))
    else $error("toggle did not invert state");
  AST_TOGGLE_B0: assert property ( // [R3]
    @(posedge sys_clk_in) disable iff (!rst_b_in)
    (fall[0] && !set_eff[0] && !clr_eff[0] && j_in[0] && k_in[0])
    |=> (state_q[0] != $past(state_q[0])))
    else $error("toggle did not invert state");
  AST_JK_SET: assert property ( // [R3]
    @(posedge sys_clk_in) disable iff (!rst_b_in)
    (fall[0] && !set_eff[0] && !clr_eff[0] && j_in[0] && !k_in[0])
    |=> q_out[0])
    else $error("J only must set");
  AST_JK_SET_B1: assert property ( // [R3]
    @(posedge sys_clk_in) disable iff (!rst_b_in)
    (fall[1] && !set_eff[1] && !clr_eff[1] && j_in[1] && !k_in[1])
    |=> q_out[1])
    else $error("J only must set");
  AST_JK_CLR: assert property ( // [R3]
    @(posedge sys_clk_in) disable iff (!rst_b_in)
    (fall[1] && !set_eff[1] && !clr_eff[1] && !j_in[1] && k_in[1])
    |=> !q_out[1])
    else $error("K only must clear");
  AST_JK_HOLD: assert property ( // [R3]
    @(posedge sys_clk_in) disable iff (!rst_b_in)
    (fall[0] && !set_eff[0] && !clr_eff[0] && !j_in[0] && !k_in[0])
    |=> $stable(state_q[0]))
    else $error("J and K low must hold");
  // Output pairing and variant wiring
  AST_COMPLEMENT: assert property ( // [R11]
    @(posedge sys_clk_in) disable iff (!rst_b_in)
    !(q_out[1] && q_b_out[1]) |-> (q_out[1] != q_b_out[1]))
    else $error("complement not inverse");
  AST_COMPLEMENT_B0: assert property ( // [R11]
    @(posedge sys_clk_in) disable iff (!rst_b_in)
    !(q_out[0] && q_b_out[0]) |-> (q_out[0] != q_b_out[0]))
    else $error("complement not inverse");
  AST_SET_ONLY: assert property ( // [R8]
    @(posedge sys_clk_in) disable iff (!rst_b_in)
    (VARIANT == `DJK_VAR_SET_ONLY) |-> (clr_eff == 2'h0))
    else $error("clear active in set-only variant");
  AST_SHARED_FALL: assert property ( // [R10]
    @(posedge sys_clk_in) disable iff (!rst_b_in)
    (VARIANT == `DJK_VAR_SHARED) |-> (fall[1] == fall[0]))
    else $error("shared variant halves saw different clock edges");
endmodule
`default_nettype wire

// *** tb/testbench.sv ***
/*
  Self-checking bench for the dual JK falling-edge flip-flop, all variants.
  Assumes pin effects settle within eight system cycles.
*/
`timescale 1ns/1ps
`default_nettype none
`include "djk_defines.svh"
module testbench;
  logic sys_clk_in;
  logic rst_b_in;
  logic [1:0] j_in, k_in, fe_clk, set_b_in, clr_b_in, q_out, q_b_out;
  logic [1:0] q_so, qb_so, q_sh, qb_sh;
  int miscompares = 0;
  int checked = 0;
  djk_top #(.VARIANT(`DJK_VAR_FULL)) dut (
    .sys_clk_in(sys_clk_in), .rst_b_in(rst_b_in), .j_in(j_in),
    .k_in(k_in), .falling_edge_clock_in(fe_clk), .set_b_in(set_b_in),
    .clr_b_in(clr_b_in), .q_out(q_out), .q_b_out(q_b_out));
  // Variant copies share the stimulus; only test_variants judges them
  djk_top #(.VARIANT(`DJK_VAR_SET_ONLY)) dut_set_only (
    .sys_clk_in(sys_clk_in), .rst_b_in(rst_b_in), .j_in(j_in),
    .k_in(k_in), .falling_edge_clock_in(fe_clk), .set_b_in(set_b_in),
    .clr_b_in(clr_b_in), .q_out(q_so), .q_b_out(qb_so));
  djk_top #(.VARIANT(`DJK_VAR_SHARED)) dut_shared (
    .sys_clk_in(sys_clk_in), .rst_b_in(rst_b_in), .j_in(j_in),
    .k_in(k_in), .falling_edge_clock_in(fe_clk), .set_b_in(set_b_in),
    .clr_b_in(clr_b_in), .q_out(q_sh), .q_b_out(qb_sh));
  // 100 MHz system clock
  initial begin
    sys_clk_in = 1'b0;
    forever #5 sys_clk_in = ~sys_clk_in;
  end
  task automatic step(input int n);
    repeat (n) @(posedge sys_clk_in);
  endtask
  // Full variant compare
  task automatic chk(input string what, input logic [1:0] eq,
                     input logic [1:0] eqb);
    chkv(what, 0, eq, eqb);
  endtask
  // Compare mid-cycle, where registered outputs have settled, then
  // resume on a rising edge so stimulus stays edge-aligned
  task automatic chkv(input string what, input int sel,
                      input logic [1:0] eq, input logic [1:0] eqb);
    logic [1:0] sq;
    logic [1:0] sqb;
    @(negedge sys_clk_in);
    sq = (sel == 1) ? q_so : (sel == 2) ? q_sh : q_out;
    sqb = (sel == 1) ? qb_so : (sel == 2) ? qb_sh : q_b_out;
    checked++;
    if (sq !== eq || sqb !== eqb) begin
      miscompares++;
      $display("[FAIL] %s expected %b/%b seen %b/%b", what, eq, eqb,
               sq, sqb);
    end
    @(posedge sys_clk_in);
  endtask
  // J/K stand well before and after the fall, as the synchroniser needs
  task automatic pulse(input logic [1:0] which, input logic [1:0] j,
                       input logic [1:0] k);
    j_in <= j;
    k_in <= k;
    step(4);
    fe_clk <= ~which;
    step(8);
    fe_clk <= 2'b11;
    step(8);
  endtask
  task automatic test_jk;
    logic [1:0] wh [7] = '{2'h1, 2'h2, 2'h3, 2'h3, 2'h3, 2'h3, 2'h3};
    logic [1:0] jv [7] = '{2'h3, 2'h0, 2'h0, 2'h3, 2'h3, 2'h0, 2'h3};
    logic [1:0] kv [7] = '{2'h0, 2'h3, 2'h0, 2'h3, 2'h3, 2'h3, 2'h0};
    logic [1:0] ev [7] = '{2'h1, 2'h1, 2'h1, 2'h2, 2'h1, 2'h0, 2'h3};
    for (int i = 0; i < 7; i++) begin
      pulse(wh[i], jv[i], kv[i]);
      chk("jk table", ev[i], ~ev[i]);
    end
    $display("test_jk done");
  endtask
  // J/K wiggle away from any falling edge
  task automatic test_quiet;
    j_in <= 2'b00;
    k_in <= 2'b11;
    step(8);
    chk("jk while clock high", 2'h3, 2'h0);
    k_in <= 2'b00;
    fe_clk <= 2'b00;
    step(8);
    k_in <= 2'b11;
    step(8);
    chk("jk while clock low", 2'h3, 2'h0);
    k_in <= 2'b00;
    step(4);
    fe_clk <= 2'b11;
    step(8);
    $display("test_quiet done");
  endtask
  task automatic test_direct;
    clr_b_in <= 2'b01;
    step(8);
    chk("clear ff1", 2'h1, 2'h2);
    pulse(2'b11, 2'b11, 2'b11);
    chk("clock blocked by clear", 2'h0, 2'h3);
    clr_b_in <= 2'b11;
    step(8);
    chk("clear released", 2'h0, 2'h3);
    set_b_in <= 2'b10;
    step(8);
    chk("set ff0", 2'h1, 2'h2);
    set_b_in <= 2'b00;
    clr_b_in <= 2'b00;
    step(8);
    chk("set and clear", 2'h3, 2'h3);
    set_b_in <= 2'b11;
    clr_b_in <= 2'b11;
    step(8);
    chk("both released", 2'h3, 2'h0);
    $display("test_direct done");
  endtask
  // Set-only ignores clear; shared takes clock and clear from pin 0
  task automatic test_variants;
    set_b_in <= 2'b00;
    step(8);
    set_b_in <= 2'b11;
    step(8);
    clr_b_in <= 2'b10;
    step(8);
    chk("full clears ff0 only", 2'h2, 2'h1);
    chkv("set-only ignores clear", 1, 2'h3, 2'h0);
    chkv("shared clear", 2, 2'h0, 2'h3);
    clr_b_in <= 2'b11;
    j_in <= 2'b11;
    k_in <= 2'b11;
    step(8);
    fe_clk <= 2'b10;
    step(8);
    chk("full toggles ff0 only", 2'h3, 2'h0);
    chkv("set-only clock", 1, 2'h2, 2'h1);
    chkv("shared clock", 2, 2'h3, 2'h0);
    fe_clk <= 2'b11;
    j_in <= 2'b00;
    k_in <= 2'b00;
    step(8);
    $display("test_variants done");
  endtask
  task automatic tally_and_finish;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // Hang guard
  initial begin
    #100000;
    miscompares++;
    tally_and_finish();
  end
  initial begin
    rst_b_in = 1'b0;
    j_in = 2'b00;
    k_in = 2'b00;
    fe_clk = 2'b11;
    set_b_in = 2'b11;
    clr_b_in = 2'b11;
    step(1);
    chk("during reset", 2'h0, 2'h3);
    rst_b_in <= 1'b1;
    step(8);
    test_jk();
    test_quiet();
    test_direct();
    test_variants();
    tally_and_finish();
  end
endmodule
`default_nettype wire
